// *** paging_pkg.sv ***
// Package: shared constants and types for the data space paging arbiter.
// Assumes a single system clock domain and an AXI4-Lite register slave.
package paging_pkg;
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned PAGE_W     = 10;
    localparam int unsigned EXT_W      = 24;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned LOW_W      = 15;
    localparam int unsigned NUM_MASTER = 3;
    localparam int unsigned UPPER_BIT  = 15;

    // Register byte offsets
    localparam logic [7:0] OFF_READ_PAGE  = 8'h00;
    localparam logic [7:0] OFF_WRITE_PAGE = 8'h04;
    localparam logic [7:0] OFF_PRIORITY   = 8'h08;
    localparam logic [7:0] OFF_STATUS     = 8'h0c;
    localparam logic [7:0] OFF_MASK       = 8'h10;
    localparam logic [7:0] OFF_GRANT      = 8'h14;

    // Reset values and encodings
    localparam logic [PAGE_W-1:0] PAGE_RESET = 10'h001;
    localparam logic [PAGE_W-1:0] PAGE_ZERO  = 10'h000;
    localparam logic [15:0]       PRIO_DEFAULT = 16'h0000;
    localparam logic [15:0]       PRIO_DMA_UP  = 16'h0020;

    // Master indices
    localparam int unsigned M_CPU = 0;
    localparam int unsigned M_DMA = 1;
    localparam int unsigned M_DBG = 2;

    // Status bit positions
    localparam int unsigned ST_TRAP    = 0;
    localparam int unsigned ST_CONTEND = 1;
    localparam int unsigned ST_W       = 2;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] effective_addr;
        logic [DATA_W-1:0] wdata;
    } master_req_s;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [EXT_W-1:0]  addr;
        logic [DATA_W-1:0] wdata;
    } mem_req_s;
endpackage

// *** page_translate.sv ***
// Page translation of one base data address into the extended window.
// Assumes page selectors come from registers on the same clock.
`timescale 1ns/10ps
module page_translate
    import paging_pkg::*;
(
    input  wire logic [ADDR_W-1:0] effective_addr_i,
    input  wire logic              we_i,
    input  wire logic [PAGE_W-1:0] read_page_select_i,
    input  wire logic [PAGE_W-1:0] write_page_select_i,
    output logic      [EXT_W-1:0]  ext_addr_o,
    output logic                   addr_error_o
);
    logic              upper;
    logic [PAGE_W-1:0] page;

    // Page choice and address formation
    assign upper = effective_addr_i[UPPER_BIT];
    assign page  = we_i ? write_page_select_i : read_page_select_i;  // [RULE13]
    // Only the page bits that fit the extended address are used; higher pages alias
    assign ext_addr_o = upper
        ? {page[EXT_W-LOW_W-1:0], effective_addr_i[LOW_W-1:0]}               // [RULE6] [RULE7]
        : {{(EXT_W-LOW_W){1'b0}}, effective_addr_i[LOW_W-1:0]};              // [RULE1]
    // Trap on any page that would land on page zero, aliases included
    assign addr_error_o = upper && (page[EXT_W-LOW_W-1:0] == '0);             // [RULE2] [RULE4]
endmodule

// *** data_space_paging_arbiter.sv ***
// Data memory access unit: page translation plus three-master arbiter.
// Assumes masters hold requests until granted; memory answers in one cycle.
// Operation
// [RULE1] Lower-half base addresses go straight to page zero regardless of selectors.
// [RULE2] Upper-half addresses never reach page zero when the selector is zero.
// [RULE3] Reset loads both read and write page selectors with one.
// [RULE4] Upper-half access with a zero selector raises an address error trap.
// [RULE5] Software writes of zero to a page selector are ignored.
// [RULE6] Nonzero pages are reached only through upper-half addresses plus the selector.
// [RULE7] Extended address equals page times 32 KB plus low fifteen bits; the code keeps only nine page bits, so pages above 511 alias.
// [RULE8] Arbiter resolves accesses from core, DMA and debug masters.
// [RULE9] Coincident requests grant only the top master; others stall.
// [RULE10] Default order: core highest, DMA next, debug lowest.
// [RULE11] Priority zero gives default; 0x0020 puts DMA above core.
// [RULE12] Masters above and below the core keep their relative order.
// [RULE13] Reads use the read selector, writes use the write selector.
`timescale 1ns/10ps
module data_space_paging_arbiter
    import paging_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic                    reset_i,
    input  wire paging_pkg::master_req_s cpu_req_i,
    input  wire paging_pkg::master_req_s dma_req_i,
    input  wire paging_pkg::master_req_s dbg_req_i,
    output logic [2:0]                   grant_o,
    output logic [2:0]                   stall_o,
    output paging_pkg::mem_req_s         mem_req_o,
    output logic                         addr_error_trap_o,
    output logic                         irq_o,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    import paging_pkg::*;

    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    // Registers
    logic [PAGE_W-1:0] read_page_q;
    logic [PAGE_W-1:0] write_page_q;
    logic [15:0]       prio_q;
    logic [ST_W-1:0]   status_q;
    logic [ST_W-1:0]   mask_q;
    logic [2:0]        grant_q;
    mem_req_s          mem_q;
    logic              trap_q;

    // AXI state
    logic              aw_held_q;
    logic [7:0]        aw_addr_q;
    logic              w_held_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    // Maps a byte offset to a legal register flag
    function automatic logic is_mapped(input logic [7:0] off);
        is_mapped = (off == OFF_READ_PAGE) || (off == OFF_WRITE_PAGE) || (off == OFF_PRIORITY)
                 || (off == OFF_STATUS) || (off == OFF_MASK) || (off == OFF_GRANT);
    endfunction

    // Applies byte strobes to the low half word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Request bundle as an array
    master_req_s req_a [NUM_MASTER];
    assign req_a[M_CPU] = cpu_req_i;
    assign req_a[M_DMA] = dma_req_i;
    assign req_a[M_DBG] = dbg_req_i;

    logic [2:0] req_vec;
    assign req_vec = {dbg_req_i.req, dma_req_i.req, cpu_req_i.req};  // [RULE8]

    // Priority selection: DMA raised only for the one allowed value
    logic       dma_raised;
    logic [2:0] grant_d;
    assign dma_raised = (prio_q == PRIO_DMA_UP);                      // [RULE11]
    always_comb begin
        grant_d = 3'b000;
        if (dma_raised && req_vec[M_DMA]) begin                       // [RULE12]
            grant_d[M_DMA] = 1'b1;
        end else if (req_vec[M_CPU]) begin                            // [RULE10]
            grant_d[M_CPU] = 1'b1;
        end else if (req_vec[M_DMA]) begin
            grant_d[M_DMA] = 1'b1;
        end else if (req_vec[M_DBG]) begin
            grant_d[M_DBG] = 1'b1;
        end
    end

    // Winner bundle
    master_req_s win;
    assign win = grant_d[M_DMA] ? req_a[M_DMA] : (grant_d[M_DBG] ? req_a[M_DBG] : req_a[M_CPU]);

    // Translation of the winning address
    logic [EXT_W-1:0] ext_addr;
    logic             addr_err;
    page_translate u_translate (
        .effective_addr_i    (win.effective_addr),
        .we_i                (win.we),
        .read_page_select_i  (read_page_q),
        .write_page_select_i (write_page_q),
        .ext_addr_o          (ext_addr),
        .addr_error_o        (addr_err)
    );

    logic any_grant;
    logic contend;
    assign any_grant = |grant_d;
    assign contend   = (req_vec != 3'b000) && ((req_vec & (req_vec - 3'b001)) != 3'b000);

    // Grant and memory request; losers stall this cycle
    assign grant_o           = grant_d;                               // [RULE9]
    assign stall_o           = req_vec & ~grant_d;                    // [RULE9]
    assign mem_req_o         = mem_q;
    assign addr_error_trap_o = trap_q;

    // Memory request register, blocked on address error
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            mem_q   <= '0;
            trap_q  <= 1'b0;
            grant_q <= 3'b000;
        end else begin
            mem_q.req   <= any_grant && !addr_err;                    // [RULE4]
            mem_q.we    <= win.we;
            mem_q.addr  <= ext_addr;                                  // [RULE7]
            mem_q.wdata <= win.wdata;
            trap_q      <= any_grant && addr_err;                     // [RULE4]
            if (any_grant) begin
                grant_q <= grant_d;
            end
        end
    end

    // AXI write channel decode
    logic        aw_take;
    logic        w_take;
    logic        wr_go;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wr_go   = (aw_held_q || aw_take) && (w_held_q || w_take);
    assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    assign wr_ok   = is_mapped(wr_addr);

    logic [15:0] wr_half;
    logic [15:0] rp_new;
    logic [15:0] wp_new;
    assign wr_half = merge16(16'h0000, wr_data, wr_strb);
    assign rp_new  = merge16({6'h00, read_page_q}, wr_data, wr_strb);
    assign wp_new  = merge16({6'h00, write_page_q}, wr_data, wr_strb);

    // Write handshake tracking
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OK;
        end else begin
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RESP_OK : RESP_ERR;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // Software register updates
    logic [ST_W-1:0] events;
    logic [ST_W-1:0] clr;
    assign events = {contend, any_grant && addr_err};
    assign clr    = (wr_go && wr_addr == OFF_STATUS) ? wr_data[ST_W-1:0] & {ST_W{wr_strb[0]}} : '0;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            read_page_q  <= PAGE_RESET;                               // [RULE3]
            write_page_q <= PAGE_RESET;                               // [RULE3]
            prio_q       <= PRIO_DEFAULT;                             // [RULE10]
            status_q     <= '0;
            mask_q       <= '0;
        end else begin
            if (wr_go && wr_addr == OFF_READ_PAGE && rp_new[PAGE_W-1:0] != PAGE_ZERO) begin
                read_page_q <= rp_new[PAGE_W-1:0];                    // [RULE5]
            end
            if (wr_go && wr_addr == OFF_WRITE_PAGE && wp_new[PAGE_W-1:0] != PAGE_ZERO) begin
                write_page_q <= wp_new[PAGE_W-1:0];                   // [RULE5]
            end
            if (wr_go && wr_addr == OFF_PRIORITY) begin
                prio_q <= merge16(prio_q, wr_data, wr_strb);          // [RULE11]
            end
            if (wr_go && wr_addr == OFF_MASK) begin
                mask_q <= wr_half[ST_W-1:0];
            end
            status_q <= (status_q & ~clr) | events;                   // Set beats clear
        end
    end

    assign irq_o         = |(status_q & mask_q);
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // Read channel
    logic [31:0] rd_mux;
    assign s_axi_arready = !rvalid_q;
    assign rd_mux =
        (s_axi_araddr == OFF_READ_PAGE)  ? {22'h000000, read_page_q} :
        (s_axi_araddr == OFF_WRITE_PAGE) ? {22'h000000, write_page_q} :
        (s_axi_araddr == OFF_PRIORITY)   ? {16'h0000, prio_q} :
        (s_axi_araddr == OFF_STATUS)     ? {30'h00000000, status_q} :
        (s_axi_araddr == OFF_MASK)       ? {30'h00000000, mask_q} :
        (s_axi_araddr == OFF_GRANT)      ? {29'h00000000, grant_q} : 32'h0000_0000;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= is_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
endmodule

// *** dspa_properties.sv ***
// Checker: arbitration and paging relations seen at the arbiter ports.
// Assumes a bind onto data_space_paging_arbiter and one clock domain.
`timescale 1ns/10ps
module dspa_properties
    import paging_pkg::*;
(
    input wire logic                    sys_clk_i,
    input wire logic                    reset_i,
    input wire paging_pkg::master_req_s cpu_req_i,
    input wire paging_pkg::master_req_s dma_req_i,
    input wire paging_pkg::master_req_s dbg_req_i,
    input wire logic [2:0]              grant_o,
    input wire logic [2:0]              stall_o,
    input wire paging_pkg::mem_req_s    mem_req_o,
    input wire logic                    addr_error_trap_o
);
    // Pending requests and the request of the granted master
    wire logic [2:0]  reqs = {dbg_req_i.req, dma_req_i.req, cpu_req_i.req};
    wire master_req_s sel  = grant_o[0] ? cpu_req_i : (grant_o[1] ? dma_req_i : dbg_req_i);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_grant_onehot: assert property ($onehot0(grant_o)) else $error("grant not one-hot");
    a_grant_needs_req: assert property ((grant_o & ~reqs) == 3'h0) else $error("grant without req");
    a_req_is_served: assert property (|reqs |-> grant_o != 3'h0) else $error("requests but no grant");
    a_debug_lowest: assert property (grant_o[2] |-> !cpu_req_i.req && !dma_req_i.req)
        else $error("debug granted over others");
    a_stall_mirror: assert property (stall_o == (reqs & ~grant_o)) else $error("stall mismatch");
    a_low_direct: assert property (|grant_o && !sel.effective_addr[15] |=> mem_req_o.req &&
        mem_req_o.addr == {9'h000, $past(sel.effective_addr[14:0])}) else $error("low half not page zero");
    a_upper_paged: assert property (|grant_o && sel.effective_addr[15] |=> addr_error_trap_o ||
        (mem_req_o.req && mem_req_o.addr[23:15] != 9'h000 &&
        mem_req_o.addr[14:0] == $past(sel.effective_addr[14:0]))) else $error("upper half map wrong");
    a_write_path: assert property (|grant_o |=> addr_error_trap_o ||
        (mem_req_o.we == $past(sel.we) && mem_req_o.wdata == $past(sel.wdata))) else $error("payload lost");
    a_idle_quiet: assert property (grant_o == 3'h0 |=> !mem_req_o.req && !addr_error_trap_o)
        else $error("access without grant");
    a_trap_blocks: assert property (addr_error_trap_o |-> !mem_req_o.req) else $error("trap with access");
endmodule
bind data_space_paging_arbiter dspa_properties chk_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .cpu_req_i(cpu_req_i), .dma_req_i(dma_req_i), .dbg_req_i(dbg_req_i), .grant_o(grant_o),
    .stall_o(stall_o), .mem_req_o(mem_req_o), .addr_error_trap_o(addr_error_trap_o));

// *** master_port.sv ***
// Partner: one bus master that holds its request until granted.
// Assumes the bench loads a command only while the master is idle.
`timescale 1ns/10ps
module master_port
    import paging_pkg::*;
(
    input  wire logic                    sys_clk_i,
    input  wire logic                    reset_i,
    input  wire logic                    load_i,
    input  wire logic                    grant_i,
    input  wire paging_pkg::master_req_s cmd_i,
    output paging_pkg::master_req_s      req_o
);
    // Hold until taken, then scramble the released payload
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            req_o <= '0;
        end else if (load_i) begin
            req_o <= cmd_i;
        end else if (req_o.req && grant_i) begin
            req_o.req            <= 1'b0;
            req_o.effective_addr <= ~req_o.effective_addr;
            req_o.wdata          <= ~req_o.wdata;
        end
    end
endmodule

// *** tb.sv ***
// Testbench: register access, paging and priority checks of the arbiter.
// Assumes master_port partners and the bound property checker.
`timescale 1ns/10ps
module tb;
    import paging_pkg::*;
    logic        sys_clk_i, reset_i, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, trap, irq;
    logic [2:0]  load, grant, stall;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, q, r;
    logic [1:0]  bresp, rresp, rs;
    logic [9:0]  rpage, wpage;
    master_req_s cmd [3];
    master_req_s rq [3];
    mem_req_s    mem;
    logic [40:0] expq [$];
    int          n_errors, compares, seed, traps_due;
    for (genvar i = 0; i < 3; i++) begin : g_m
        master_port mp_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .load_i(load[i]), .grant_i(grant[i]),
            .cmd_i(cmd[i]), .req_o(rq[i]));
    end
    data_space_paging_arbiter dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cpu_req_i(rq[0]),
        .dma_req_i(rq[1]), .dbg_req_i(rq[2]), .grant_o(grant), .stall_o(stall), .mem_req_o(mem),
        .addr_error_trap_o(trap), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial begin
        sys_clk_i = 0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    task chk(input logic [40:0] got, input logic [40:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One AXI4-Lite transfer; waits for the response
    task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (wr) begin
            awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        end else begin
            araddr <= a; arvalid <= 1; rready <= 1;
        end
        do begin
            @(posedge sys_clk_i);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (arvalid && arready) arvalid <= 0;
        end while (!(wr ? bvalid : rvalid));
        q = rdata; rs = wr ? bresp : rresp; bready <= 0; rready <= 0;
        @(posedge sys_clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        axi(1, a, d);
        chk(rs, 2'b00);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axi(0, a, 0);
        chk({q, rs}, {e, er});
    endtask
    // Load a master command and note its expected memory access
    task put(input int m, input logic we, input logic [15:0] ea, input logic [15:0] wd);
        logic [9:0] pg;
        pg = we ? wpage : rpage;
        cmd[m] <= '{req: 1'b1, we: we, effective_addr: ea, wdata: wd};
        load[m] <= 1;
        expq.push_back({ea[15] ? {pg[8:0], ea[14:0]} : {9'h000, ea[14:0]}, we, wd});
    endtask
    task go;
        @(posedge sys_clk_i);
        load <= 0;
        #1;
    endtask
    task wait_idle;
        for (int k = 0; k < 50 && (rq[0].req | rq[1].req | rq[2].req); k++) @(posedge sys_clk_i);
        repeat (2) @(posedge sys_clk_i);
    endtask
    // Take the oldest note whenever the memory side shows an access
    always @(posedge sys_clk_i) begin
        if (!reset_i && trap) begin
            chk(traps_due > 0, 1);
            traps_due--;
        end
        if (!reset_i && mem.req) begin
            if (expq.size() == 0) chk(1, 0);
            else chk({mem.addr, mem.we, mem.wdata}, expq.pop_front());
        end
    end
    task give_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        reset_i = 1; load = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; rpage = 1; wpage = 1; seed = 32'ha9ae; traps_due = 0;
        for (int i = 0; i < 3; i++) cmd[i] = '0;
        repeat (3) @(posedge sys_clk_i);
        reset_i <= 0;
        rd(OFF_READ_PAGE, 1, 0);
        rd(OFF_WRITE_PAGE, 1, 0);
        rd(OFF_PRIORITY, 0, 0);
        rd(8'h3c, 0, 2'b10);
        for (int i = 0; i < 12; i++) begin
            if (i == 6) begin
                wr(OFF_READ_PAGE, 3);
                wr(OFF_WRITE_PAGE, 2);
                rpage = 3; wpage = 2;
            end
            r = $random(seed);
            put(i % 3, r[16], {r[17], r[14:0]}, r[31:16]);
            go();
            wait_idle();
        end
        wr(OFF_READ_PAGE, 0);
        rd(OFF_READ_PAGE, 3, 0);
        wr(OFF_WRITE_PAGE, 0);
        rd(OFF_WRITE_PAGE, 2, 0);
        for (int p = 0; p < 2; p++) begin
            wr(OFF_PRIORITY, p ? 32'h20 : 32'h0);
            r = $random(seed);
            put(p, 1'b0, {1'b1, r[14:0]}, r[31:16]);
            put(1 - p, 1'b1, 16'hffff, r[15:0]);
            put(2, 1'b0, 16'h8000, 16'h0);
            go();
            chk({grant, stall}, p ? 6'b010_101 : 6'b001_110);
            wait_idle();
        end
        // Page that aliases onto page zero must trap, not reach memory
        wr(OFF_READ_PAGE, 32'h200);
        traps_due = 1;
        cmd[0] <= '{req: 1'b1, we: 1'b0, effective_addr: 16'h8123, wdata: 16'h0};
        load[0] <= 1;
        go();
        wait_idle();
        chk(traps_due, 0);
        chk(irq, 0);
        rd(OFF_STATUS, 32'h3, 0);
        wr(OFF_MASK, 32'h2);
        chk(irq, 1);
        wr(OFF_STATUS, 32'h2);
        chk(irq, 0);
        rd(OFF_STATUS, 32'h1, 0);
        chk(expq.size(), 0);
        give_verdict();
    end
endmodule
